// File: hw/pll_lowpower_break_ctl.sv
// pll low-power, break protection and lock status control logic
//
// Implementation choices: the register addresses and the APB interface to the registers.
`timescale 1ns/100ps
`include "pll_lowpower_break_ctl_cfg.svh"
module pll_lowpower_break_ctl (
  // clock, reset, enable
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // apb slave
  input wire pll_lowpower_break_ctl_pkg::apb_req_t APB_REQ_I,
  output pll_lowpower_break_ctl_pkg::apb_rsp_t APB_RSP_O,
  // system integration unit
  input wire logic OSC_ENABLE_FROM_SYSCTL_I,
  input wire logic BREAK_STATE_I,
  input wire logic BREAK_CLEAR_ENABLE_I,
  // analog pll side
  input wire logic XTAL_CLK_I,
  input wire logic VCO_CLK_I,
  input wire logic PLL_TRACKING_I,
  input wire logic PLL_LOCKED_I,
  // clock and pll control outputs
  output logic CRYSTAL_REF_CLOCK_O,
  output logic BASE_CLOCK_OUT_O,
  output logic PLL_POWER_ON_O,
  output logic PLL_TRACKING_MODE_O,
  // interrupts
  output logic PLL_IRQ_OUT_O,
  output logic IRQ_O
);
  import pll_lowpower_break_ctl_pkg::*;

  // ==========================================================
  // helpers
  function automatic logic hit(input logic [11:0] a, input logic [11:0] off);
    hit = (a == off);
  endfunction

  // ==========================================================
  // bus decode
  logic acc;
  logic wr;
  logic setup_rd;
  logic mapped;
  logic [31:0] w;
  logic [11:0] a;
  logic osc_en;
  logic clr_ok;
  logic ctl_touch;
  logic wr_ctl;
  logic wr_bw;
  logic wr_iclr;
  logic wr_ien;

  assign a = APB_REQ_I.paddr;
  assign w = APB_REQ_I.pwdata;
  assign acc = APB_REQ_I.psel & APB_REQ_I.penable;
  assign wr = acc & APB_REQ_I.pwrite;
  assign setup_rd = APB_REQ_I.psel & ~APB_REQ_I.penable & ~APB_REQ_I.pwrite;
  assign mapped = hit(a, `OFF_CTL) | hit(a, `OFF_BW) | hit(a, `OFF_IST)
                | hit(a, `OFF_ICLR) | hit(a, `OFF_IEN);
  assign osc_en = OSC_ENABLE_FROM_SYSCTL_I;
  // clears are allowed outside break, or in break when enabled
  assign clr_ok = ~BREAK_STATE_I | BREAK_CLEAR_ENABLE_I;
  assign ctl_touch = acc & hit(a, `OFF_CTL);
  // one decode per register keeps the write processes short
  assign wr_ctl = wr & hit(a, `OFF_CTL);
  assign wr_bw = wr & hit(a, `OFF_BW);
  assign wr_iclr = wr & hit(a, `OFF_ICLR);
  assign wr_ien = wr & hit(a, `OFF_IEN);

  // ==========================================================
  // registers and state
  osc_state_t osc_state_reg;
  logic ie_reg;
  logic pon_reg;
  logic sel_reg;
  logic auto_reg;
  logic trk_man_reg;
  logic lock_reg;
  logic trk_reg;
  logic flag_reg;
  logic [2:0] ist_reg;
  logic [2:0] ien_reg;
  logic [31:0] prdata_reg;
  logic [31:0] prdata_next;
  logic xtal_reg;
  logic base_reg;
  logic src_prev_reg;
  logic pll_irq_reg;
  logic irq_reg;
  logic stop_entry;
  logic lock_chg;
  logic trk_rise;
  logic trk_rd;
  logic src;
  logic [2:0] ev;

  assign stop_entry = (osc_state_reg == OSC_RUN) & ~osc_en;
  // a change is only seen while automatic mode samples lock
  assign lock_chg = auto_reg & (PLL_LOCKED_I != lock_reg);
  assign trk_rise = auto_reg & PLL_TRACKING_I & ~trk_reg;
  assign trk_rd = auto_reg ? trk_reg : trk_man_reg;
  assign ev = {stop_entry, trk_rise, lock_chg};

  // ==========================================================
  // stop tracking
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      osc_state_reg <= OSC_RUN;
    end else if (CE_I) begin
      unique case (osc_state_reg)
        OSC_RUN: begin
          if (!osc_en) begin
            osc_state_reg <= OSC_STOPPED;
          end
        end
        OSC_STOPPED: begin
          if (osc_en) begin
            osc_state_reg <= OSC_RUN;
          end
        end
      endcase
    end
  end

  // ==========================================================
  // pll control register
  // no wait input exists: wait mode changes nothing here
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ie_reg <= 1'b0;
      pon_reg <= `RST_PON;
    end else if (CE_I) begin
      if (wr_ctl) begin
        ie_reg <= w[`CTL_IE];
        // power cannot drop while the vco drives the base clock
        pon_reg <= w[`CTL_PON] | sel_reg;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      sel_reg <= 1'b0;
    end else if (CE_I) begin
      if (!osc_en) begin
        sel_reg <= 1'b0;
      end else if (wr_ctl) begin
        // old power bit: selecting the vco from off takes two writes
        sel_reg <= w[`CTL_SEL] & pon_reg;
      end
    end
  end

  // set wins over a same-cycle clear
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      flag_reg <= 1'b0;
    end else if (CE_I) begin
      if (!auto_reg) begin
        flag_reg <= 1'b0;
      end else if (lock_chg) begin
        flag_reg <= 1'b1;
      end else if (ctl_touch && clr_ok) begin
        flag_reg <= 1'b0;
      end
    end
  end

  // ==========================================================
  // bandwidth register
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      auto_reg <= 1'b0;
      trk_man_reg <= 1'b0;
    end else if (CE_I) begin
      if (wr_bw) begin
        auto_reg <= w[`BW_AUTO];
        // manual value survives an automatic period untouched
        if (!auto_reg) begin
          trk_man_reg <= w[`BW_TRACK];
        end
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      lock_reg <= 1'b0;
      trk_reg <= 1'b0;
    end else if (CE_I) begin
      lock_reg <= auto_reg & PLL_LOCKED_I;
      trk_reg <= auto_reg & PLL_TRACKING_I;
    end
  end

  // ==========================================================
  // interrupt status, clear, enable
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ist_reg <= 3'h0;
    end else if (CE_I) begin
      if (wr_iclr && clr_ok) begin
        ist_reg <= (ist_reg & ~w[2:0]) | ev;
      end else begin
        ist_reg <= ist_reg | ev;
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      ien_reg <= `RST_IEN;
    end else if (CE_I) begin
      if (wr_ien) begin
        ien_reg <= w[2:0];
      end
    end
  end

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      irq_reg <= 1'b0;
      pll_irq_reg <= 1'b0;
    end else if (CE_I) begin
      irq_reg <= |(ist_reg & ien_reg);
      pll_irq_reg <= osc_en & ie_reg & flag_reg;
    end
  end

  // ==========================================================
  // clock outputs
  // clocks are sampled levels, so the base clock is limited to a quarter of sys rate and crystal ref to half
  assign src = sel_reg ? (VCO_CLK_I & pon_reg) : XTAL_CLK_I;

  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      xtal_reg <= 1'b0;
      base_reg <= 1'b0;
      src_prev_reg <= 1'b0;
    end else if (CE_I) begin
      if (!osc_en) begin
        xtal_reg <= 1'b0;
        base_reg <= 1'b0;
        src_prev_reg <= 1'b0;
      end else begin
        xtal_reg <= XTAL_CLK_I;
        src_prev_reg <= src;
        if (src && !src_prev_reg) begin
          base_reg <= ~base_reg;
        end
      end
    end
  end

  // ==========================================================
  // read data
  // unmapped and write-only offsets read as zero
  always_comb begin
    prdata_next = 32'h0000_0000;
    if (hit(a, `OFF_CTL)) begin
      prdata_next[7:0] = {ie_reg, flag_reg, pon_reg, sel_reg, `CTL_UNUSED};
    end else if (hit(a, `OFF_BW)) begin
      prdata_next[7:0] = {auto_reg, lock_reg, trk_rd, 5'h00};
    end else if (hit(a, `OFF_IST)) begin
      prdata_next[2:0] = ist_reg;
    end else if (hit(a, `OFF_IEN)) begin
      prdata_next[2:0] = ien_reg;
    end
  end

  // loaded in the setup cycle: the flag the access then clears is still shown
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      prdata_reg <= 32'h0000_0000;
    end else if (CE_I) begin
      if (setup_rd) begin
        prdata_reg <= prdata_next;
      end
    end
  end

  // ==========================================================
  // outputs
  assign APB_RSP_O.prdata = prdata_reg;
  assign APB_RSP_O.pready = 1'b1;
  assign APB_RSP_O.pslverr = acc & ~mapped;
  assign CRYSTAL_REF_CLOCK_O = xtal_reg;
  assign BASE_CLOCK_OUT_O = base_reg;
  assign PLL_POWER_ON_O = pon_reg;
  assign PLL_TRACKING_MODE_O = trk_rd;
  assign PLL_IRQ_OUT_O = pll_irq_reg;
  assign IRQ_O = irq_reg;
endmodule

// File: hw/pll_lowpower_break_ctl_cfg.svh
// constants for the pll low-power and break control block
//
// What this block does
// - wait mode leaves clock generator, pll power, selection and outputs untouched.
// - oscillator enable low forces crystal ref, base clock and pll irq low.
// - stop entry with vco selected clears base clock select in hardware.
// - after stop, crystal ref halved drives base clock; select stays clear.
// - break clear enable at 1 lets a clear during break take effect.
// - break clear enable at 0 protects the lock-change flag during break.
// - automatic mode: acquisition status bit sets when acquisition ends.
// - automatic mode: lock bit sets when lock is reached.
// - outside break, any control register access clears the lock-change flag.
// - select 1 routes halved vco clock, 0 halved crystal ref.
// - automatic mode: acquisition status is read-only, 1 tracking, 0 acquisition.
// - automatic mode: every lock change sets the flag, irq enable or not.
`ifndef PLL_LOWPOWER_BREAK_CTL_CFG_SVH
`define PLL_LOWPOWER_BREAK_CTL_CFG_SVH

// ==========================================================
// register byte offsets
`define OFF_CTL 12'h000
`define OFF_BW 12'h004
`define OFF_IST 12'h008
`define OFF_ICLR 12'h00C
`define OFF_IEN 12'h010

// ==========================================================
// field positions
`define CTL_IE 7
`define CTL_FLAG 6
`define CTL_PON 5
`define CTL_SEL 4
`define CTL_UNUSED 4'hF
`define BW_AUTO 7
`define BW_LOCK 6
`define BW_TRACK 5
`define EV_LOCK 0
`define EV_TRK 1
`define EV_STOP 2

// ==========================================================
// reset values
`define RST_PON 1'b1
`define RST_IEN 3'h0

`endif

// File: hw/pll_lowpower_break_ctl_pkg.sv
// types for the pll low-power and break control block
package pll_lowpower_break_ctl_pkg;
  typedef struct packed {
    logic psel;
    logic penable;
    logic pwrite;
    logic [11:0] paddr;
    logic [31:0] pwdata;
  } apb_req_t;

  typedef struct packed {
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
  } apb_rsp_t;

  typedef enum logic [0:0] {
    OSC_RUN = 1'b0,
    OSC_STOPPED = 1'b1
  } osc_state_t;
endpackage

// File: tb/pll_far_model.sv
// crystal, vco and analog loop model beside the control block
`timescale 1ns/100ps
module pll_far_model (
  // clock and control
  input wire logic clk_i,
  input wire logic pon_i,
  input wire logic lock_req_i,
  // analog side
  output logic xtal_o,
  output logic vco_o,
  output logic trk_o,
  output logic lck_o
);
  logic [2:0] div_reg;
  initial begin
    {div_reg, xtal_o, vco_o, trk_o, lck_o} = '0;
  end
  // crystal is slow so a vco-sourced base clock is told apart
  always @(posedge clk_i) begin
    div_reg <= div_reg + 3'h1;
    xtal_o <= div_reg[2];
    vco_o <= !vco_o & pon_i;
    trk_o <= pon_i & lock_req_i;
    lck_o <= trk_o & pon_i & lock_req_i;
  end
endmodule

// File: tb/pll_lowpower_break_ctl_properties.sv
// assertions and covers for the pll low-power and break control block
`timescale 1ns/100ps
module pll_lowpower_break_ctl_properties (
  // clock and reset
  input wire logic CLK_SYS_I,
  input wire logic RST_I,
  input wire logic CE_I,
  // watched ports
  input wire pll_lowpower_break_ctl_pkg::apb_req_t APB_REQ_I,
  input wire pll_lowpower_break_ctl_pkg::apb_rsp_t APB_RSP_O,
  input wire logic OSC_ENABLE_FROM_SYSCTL_I,
  input wire logic XTAL_CLK_I,
  input wire logic CRYSTAL_REF_CLOCK_O,
  input wire logic BASE_CLOCK_OUT_O,
  input wire logic PLL_POWER_ON_O,
  input wire logic PLL_IRQ_OUT_O
);
  import pll_lowpower_break_ctl_pkg::*;
  logic acc, wr_ctl, xsrc_reg;
  assign acc = APB_REQ_I.psel & APB_REQ_I.penable;
  assign wr_ctl = acc & CE_I & APB_REQ_I.pwrite & (APB_REQ_I.paddr == 12'h000);
  // select is not a port, so mirror when crystal must be the source
  always_ff @(posedge CLK_SYS_I or posedge RST_I) begin
    if (RST_I) begin
      xsrc_reg <= 1'b1;
    end else if (!OSC_ENABLE_FROM_SYSCTL_I) begin
      xsrc_reg <= 1'b1;
    end else if (wr_ctl) begin
      xsrc_reg <= !APB_REQ_I.pwdata[4];
    end
  end
  // ==========================================================
  // properties
  default clocking cb @(posedge CLK_SYS_I);
  endclocking
  default disable iff (RST_I);
  a_stop_outputs_low:
    assert property (!OSC_ENABLE_FROM_SYSCTL_I && CE_I |=>
      !CRYSTAL_REF_CLOCK_O && !BASE_CLOCK_OUT_O && !PLL_IRQ_OUT_O) else $error("stop");
  a_ref_follows:
    assert property (OSC_ENABLE_FROM_SYSCTL_I && CE_I |=>
      CRYSTAL_REF_CLOCK_O == $past(XTAL_CLK_I)) else $error("ref copy");
  a_power_steady:
    assert property (!wr_ctl |=> $stable(PLL_POWER_ON_O)) else $error("power");
  a_base_from_xtal:
    assert property (xsrc_reg && $past(xsrc_reg) && OSC_ENABLE_FROM_SYSCTL_I &&
      $past(OSC_ENABLE_FROM_SYSCTL_I) && $changed(BASE_CLOCK_OUT_O) |->
      $past(XTAL_CLK_I) || $past(XTAL_CLK_I, 2)) else $error("base source");
  a_irq_needs_osc:
    assert property (PLL_IRQ_OUT_O && $past(CE_I) |-> $past(OSC_ENABLE_FROM_SYSCTL_I))
    else $error("irq in stop");
  a_unmapped_err:
    assert property (acc |-> APB_RSP_O.pslverr ==
      (APB_REQ_I.paddr > 12'h010 || APB_REQ_I.paddr[1:0] != 2'h0)) else $error("slverr");
  a_ready_high:
    assert property (acc |-> APB_RSP_O.pready) else $error("ready");
  a_err_reads_zero:
    assert property (acc && !APB_REQ_I.pwrite && APB_RSP_O.pslverr |->
      APB_RSP_O.prdata == 32'h0) else $error("err data");
  c_stop: cover property (!OSC_ENABLE_FROM_SYSCTL_I && CE_I);
  c_irq: cover property (PLL_IRQ_OUT_O);
  c_err: cover property (acc && APB_RSP_O.pslverr);
endmodule
bind pll_lowpower_break_ctl pll_lowpower_break_ctl_properties u_props (
  .CLK_SYS_I(CLK_SYS_I), .RST_I(RST_I), .CE_I(CE_I), .APB_REQ_I(APB_REQ_I),
  .APB_RSP_O(APB_RSP_O), .OSC_ENABLE_FROM_SYSCTL_I(OSC_ENABLE_FROM_SYSCTL_I),
  .XTAL_CLK_I(XTAL_CLK_I), .CRYSTAL_REF_CLOCK_O(CRYSTAL_REF_CLOCK_O),
  .BASE_CLOCK_OUT_O(BASE_CLOCK_OUT_O), .PLL_POWER_ON_O(PLL_POWER_ON_O),
  .PLL_IRQ_OUT_O(PLL_IRQ_OUT_O));

// File: tb/test_pll_lowpower_break_ctl.sv
// self-checking bench for the pll low-power and break control block
`timescale 1ns/100ps
module test_pll_lowpower_break_ctl;
  import pll_lowpower_break_ctl_pkg::*;
  logic clk = 0, rst = 1, osc = 1, brk = 0, bclr = 0, lreq = 0, ce = 1;
  logic xt, vc, tr, lk, cry, base, pon, pirq, irq, err, tm;
  logic [31:0] q;
  apb_req_t req = '0;
  apb_rsp_t rsp;
  int failures = 0, n_tests = 0, cyc = 0;
  always #2.5 clk = ~clk;
  pll_far_model u_far (.clk_i(clk), .pon_i(pon), .lock_req_i(lreq), .xtal_o(xt),
    .vco_o(vc), .trk_o(tr), .lck_o(lk));
  pll_lowpower_break_ctl u_dut (.CLK_SYS_I(clk), .RST_I(rst), .CE_I(ce),
    .APB_REQ_I(req), .APB_RSP_O(rsp), .OSC_ENABLE_FROM_SYSCTL_I(osc),
    .BREAK_STATE_I(brk), .BREAK_CLEAR_ENABLE_I(bclr), .XTAL_CLK_I(xt),
    .VCO_CLK_I(vc), .PLL_TRACKING_I(tr), .PLL_LOCKED_I(lk), .CRYSTAL_REF_CLOCK_O(cry),
    .BASE_CLOCK_OUT_O(base), .PLL_POWER_ON_O(pon), .PLL_TRACKING_MODE_O(tm),
    .PLL_IRQ_OUT_O(pirq), .IRQ_O(irq));
  // ==========================================================
  // shared tasks
  task automatic close_out();
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_tests++;
    if (got !== exp) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // idle edge after release keeps one assignment per step
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    req <= '{psel: 1'b1, penable: 1'b0, pwrite: w, paddr: a, pwdata: d};
    @(posedge clk);
    req.penable <= 1'b1;
    do begin
      @(posedge clk);
    end while (rsp.pready !== 1'b1);
    q = rsp.prdata;
    err = rsp.pslverr;
    req <= '0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0);
    chk(q, exp);
  endtask
  // ==========================================================
  // scenarios
  task automatic t_select();
    rd(12'h000, 32'h2F);
    apb(1'b1, 12'h000, 32'h30);
    rd(12'h000, 32'h3F);
    apb(1'b1, 12'h000, 32'h10);
    rd(12'h000, 32'h3F);
    // deselect, then power down, as software does before a wait
    apb(1'b1, 12'h000, 32'h20);
    apb(1'b1, 12'h000, 32'h00);
    rd(12'h000, 32'h0F);
    apb(1'b1, 12'h000, 32'h10);
    rd(12'h000, 32'h0F);
    apb(1'b1, 12'h000, 32'h30);
    rd(12'h000, 32'h2F);
    apb(1'b1, 12'h000, 32'h30);
    rd(12'h000, 32'h3F);
    // a write while the enable is low must leave nothing changed
    ce <= 1'b0;
    apb(1'b1, 12'h000, 32'h20);
    ce <= 1'b1;
    rd(12'h000, 32'h3F);
  endtask
  task automatic t_stop();
    osc <= 1'b0;
    @(posedge clk);
    rd(12'h000, 32'h2F);
    #1 chk(32'({cry, base, pirq}), 32'h0);
    @(posedge clk);
    osc <= 1'b1;
    rd(12'h000, 32'h2F);
    rd(12'h008, 32'h4);
    apb(1'b1, 12'h00C, 32'h4);
  endtask
  task automatic t_lock();
    apb(1'b1, 12'h010, 32'h3);
    apb(1'b1, 12'h000, 32'hA0);
    apb(1'b1, 12'h004, 32'h80);
    lreq <= 1'b1;
    repeat (6) @(posedge clk);
    rd(12'h004, 32'hE0);
    rd(12'h008, 32'h3);
    #1 chk(32'({pirq, irq}), 32'h3);
    chk(32'(tm), 32'h1);
    @(posedge clk);
    osc <= 1'b0;
    repeat (2) @(posedge clk);
    #1 chk(32'(pirq), 32'h0);
    @(posedge clk);
    osc <= 1'b1;
    repeat (2) @(posedge clk);
    @(posedge clk);
    rd(12'h000, 32'hEF);
    rd(12'h000, 32'hAF);
    apb(1'b1, 12'h010, 32'h0);
    #1 chk(32'(irq), 32'h0);
    @(posedge clk);
    apb(1'b1, 12'h00C, 32'h7);
    rd(12'h008, 32'h0);
  endtask
  task automatic t_break();
    brk <= 1'b1;
    lreq <= 1'b0;
    repeat (4) @(posedge clk);
    rd(12'h000, 32'hEF);
    rd(12'h000, 32'hEF);
    apb(1'b1, 12'h000, 32'hA0);
    rd(12'h000, 32'hEF);
    bclr <= 1'b1;
    rd(12'h000, 32'hEF);
    brk <= 1'b0;
    rd(12'h000, 32'hAF);
  endtask
  initial begin
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    @(posedge clk);
    t_select();
    t_stop();
    t_lock();
    t_break();
    rd(12'h014, 32'h0);
    chk(32'(err), 32'h1);
    close_out();
  end
  // run needs under two hundred cycles, so this only catches a hang
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      failures++;
      close_out();
    end
  end
endmodule
